/* File: bench/pchr_host_model.sv */
`timescale 1ns/100ps
module pchr_host_model (
    input wire clk_i,
    input wire ack_i,
    input wire retry_i,
    input wire [31:0] rdata_i,
    output logic pci_clk_o = 1'b0,
    output logic req_o = 1'b0,
    output logic wr_o = 1'b0,
    output logic [7:0] addr_o = 8'h00,
    output logic [3:0] be_n_o = 4'hf,
    output logic [31:0] wdata_o = 32'h0,
    output logic mem_req_o = 1'b0,
    output logic [31:0] mem_addr_o = 32'h0,
    output logic ub_req_o = 1'b0,
    output logic [10:0] ub_addr_o = 11'h0
);
    initial begin
        #7;
        forever #160 pci_clk_o = ~pci_clk_o;
    end
    // Request held until answered; silent modes time out
    task automatic cfg(input logic w, input logic [7:0] a,
        input logic [3:0] b, input logic [31:0] d,
        output logic [31:0] rd, output logic [1:0] rsp);
        integer n;
        rsp = 2'h0;
        @(posedge clk_i);
        req_o <= 1'b1;
        wr_o <= w;
        addr_o <= a;
        be_n_o <= b;
        wdata_o <= d;
        for (n = 0; n < 40 && rsp == 2'h0; n++) begin
            @(posedge clk_i);
            rd = rdata_i;
            rsp = {retry_i, ack_i};
        end
        req_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
        repeat (4) @(posedge clk_i);
    endtask
    // Memory and local bus cycles, held across a link period
    task automatic look(input logic [31:0] a);
        @(posedge clk_i);
        mem_req_o <= 1'b1;
        ub_req_o <= 1'b1;
        mem_addr_o <= a;
        ub_addr_o <= a[10:0];
        repeat (12) @(posedge clk_i);
    endtask
endmodule

/* File: bench/pchr_regs_sva.sv */
`timescale 1ns/100ps
module pchr_regs_sva #(
    parameter LAT_W = 8
) (
    input wire clk_i,
    input wire rst_i,
    input wire [2:0] host_mode_field_i,
    input wire irq_level_select_i,
    input wire core_wr_i,
    input wire core_rd_i,
    input wire core_sel_i,
    input wire cfg_ack_o,
    input wire cfg_retry_o,
    input wire mem_hit_o,
    input wire ub_hit_o,
    input wire [15:0] core_rdata_o,
    input wire core_ack_o,
    input wire [7:0] latency_count_o,
    input wire [7:0] line_size_words_o,
    input wire host_int_request_pin_n_o
);
    logic [LAT_W:0] low_q;
    always @(posedge clk_i) begin
        if (rst_i || host_int_request_pin_n_o)
            low_q <= '0;
        else
            low_q <= low_q + 1'b1;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_retry_mode_zero: assert property (cfg_retry_o |->
        $past(host_mode_field_i) == 3'h0) else $error("stray retry");
    a_ack_pci_mode: assert property (cfg_ack_o |->
        $past(host_mode_field_i) == 3'h1) else $error("stray ack");
    a_ack_single: assert property (cfg_ack_o |=>
        !cfg_ack_o [*6]) else $error("acks too close");
    a_lat_source: assert property ($changed(latency_count_o) |->
        $past(cfg_ack_o) || $past(core_ack_o)) else $error("latency moved");
    a_line_source: assert property ($changed(line_size_words_o) |->
        $past(cfg_ack_o)) else $error("line size moved");
    a_core_answer: assert property ((core_wr_i || core_rd_i) &&
        host_mode_field_i == 3'h5 |=> core_ack_o) else $error("no core ack");
    a_core_refused: assert property (core_ack_o |->
        $past(host_mode_field_i) == 3'h5) else $error("core ack in mode");
    a_core_lat_read: assert property (core_ack_o && $past(core_rd_i) &&
        !$past(core_wr_i) && !$past(core_sel_i) |->
        core_rdata_o == {8'h00, latency_count_o}) else $error("core data");
    a_window_excl: assert property (!(mem_hit_o && ub_hit_o))
        else $error("two windows hit");
    a_pulse_width: assert property ($rose(host_int_request_pin_n_o) &&
        !irq_level_select_i |-> low_q == latency_count_o + 1'b1)
        else $error("pulse width");
    a_pin_source: assert property ($fell(host_int_request_pin_n_o) |->
        $past(host_mode_field_i) inside {3'h2, 3'h3}) else $error("pin mode");
    cover property (cfg_retry_o);
    cover property (core_ack_o);
    cover property ($rose(host_int_request_pin_n_o) && !irq_level_select_i);
endmodule
bind pchr_regs pchr_regs_sva #(.LAT_W(LAT_W)) i_pchr_regs_sva (
    .clk_i, .rst_i, .host_mode_field_i, .irq_level_select_i, .core_wr_i,
    .core_rd_i, .core_sel_i, .cfg_ack_o, .cfg_retry_o, .mem_hit_o, .ub_hit_o,
    .core_rdata_o, .core_ack_o, .latency_count_o, .line_size_words_o,
    .host_int_request_pin_n_o
);

/* File: bench/testbench.sv */
`timescale 1ns/100ps
module testbench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic [2:0] host_mode_field_i = 3'h1;
    logic irq_level_select_i = 1'b0;
    logic core_wr_i = 1'b0;
    logic core_rd_i = 1'b0;
    logic core_sel_i = 1'b0;
    logic [15:0] core_wdata_i = 16'h0000;
    logic irq_req_i = 1'b0;
    wire pci_clk_i, cfg_req_i, cfg_wr_i, mem_req_i, ub_req_i, core_ack_o;
    wire cfg_ack_o, cfg_retry_o, mem_hit_o, ub_hit_o, host_int_request_pin_n_o;
    wire [7:0] cfg_addr_i, latency_count_o, line_size_words_o;
    wire [3:0] cfg_be_n_i;
    wire [31:0] cfg_wdata_i, pci_addr_data_lines_i, cfg_rdata_o;
    wire [10:0] local_bus_addr_lines_i;
    wire [11:0] mem_reg_sel_o;
    wire [2:0] ub_reg_sel_o;
    wire [15:0] core_rdata_o;
    integer bad_count = 0;
    integer total_checks = 0;
    integer k;
    integer m;
    logic [31:0] rd;
    logic [1:0] rsp;
    logic [15:0] crd;
    pchr_regs #(.LAT_W(8)) i_pchr_regs (.clk_i, .rst_i, .ce_i,
        .host_mode_field_i, .irq_level_select_i, .pci_clk_i, .cfg_req_i,
        .cfg_wr_i, .cfg_addr_i, .cfg_be_n_i, .cfg_wdata_i, .mem_req_i,
        .pci_addr_data_lines_i, .ub_req_i, .local_bus_addr_lines_i,
        .core_wr_i, .core_rd_i, .core_sel_i, .core_wdata_i, .irq_req_i,
        .cfg_rdata_o, .cfg_ack_o, .cfg_retry_o, .mem_hit_o, .mem_reg_sel_o,
        .ub_hit_o, .ub_reg_sel_o, .core_rdata_o, .core_ack_o,
        .latency_count_o, .line_size_words_o, .host_int_request_pin_n_o);
    pchr_host_model i_pchr_host_model (.clk_i, .ack_i(cfg_ack_o),
        .retry_i(cfg_retry_o), .rdata_i(cfg_rdata_o), .pci_clk_o(pci_clk_i),
        .req_o(cfg_req_i), .wr_o(cfg_wr_i), .addr_o(cfg_addr_i),
        .be_n_o(cfg_be_n_i), .wdata_o(cfg_wdata_i), .mem_req_o(mem_req_i),
        .mem_addr_o(pci_addr_data_lines_i), .ub_req_o(ub_req_i),
        .ub_addr_o(local_bus_addr_lines_i));
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    task automatic test_done;
        $display("checks %0d errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] e,
        input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic cfgc(input logic w, input logic [7:0] a,
        input logic [3:0] b, input logic [31:0] d, input logic [1:0] er,
        input logic [31:0] ed);
        i_pchr_host_model.cfg(w, a, b, d, rd, rsp);
        check("response", {30'h0, er}, {30'h0, rsp});
        if (!w)
            check("read data", ed, rd);
        if (rsp === 2'h0 && er != 2'h0)
            test_done;
    endtask
    task automatic core(input logic w, input logic s, input logic [15:0] d);
        integer n;
        @(posedge clk_i);
        core_wr_i <= w;
        core_rd_i <= ~w;
        core_sel_i <= s;
        core_wdata_i <= d;
        @(posedge clk_i);
        core_wr_i <= 1'b0;
        core_rd_i <= 1'b0;
        for (n = 0; n < 8 && core_ack_o !== 1'b1; n++)
            @(posedge clk_i);
        crd = core_rdata_o;
        if (n == 8) begin
            bad_count++;
            test_done;
        end
    endtask
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        cfgc(0, 8'h0c, 4'h0, 0, 2'h1, 32'h0);
        cfgc(0, 8'h10, 4'h0, 0, 2'h1, 32'h0);
        cfgc(1, 8'h0c, 4'h0, 32'hffffffff, 2'h1, 0);
        cfgc(0, 8'h0c, 4'h0, 0, 2'h1, 32'h0000ffff);
        cfgc(1, 8'h0c, 4'hd, 32'h00000500, 2'h1, 0);
        cfgc(0, 8'h0c, 4'h0, 0, 2'h1, 32'h000005ff);
        check("line size", 8'hff, line_size_words_o);
        cfgc(1, 8'h10, 4'h0, 32'hffffffff, 2'h1, 0);
        cfgc(0, 8'h10, 4'h0, 0, 2'h1, 32'hffff0000);
        cfgc(1, 8'h10, 4'h7, 32'h12000000, 2'h1, 0);
        cfgc(0, 8'h10, 4'h0, 0, 2'h1, 32'h12ff0000);
        i_pchr_host_model.look(32'h12ff0abc);
        check("mem hit", 1, mem_hit_o);
        check("mem sel", 12'habc, mem_reg_sel_o);
        i_pchr_host_model.look(32'h12ff1abc);
        check("mem miss", 0, mem_hit_o);
        for (m = 0; m < 4; m++) begin
            host_mode_field_i <= 3'(12'o5320 >> (3 * m));
            cfgc(1, 8'h0c, 4'h0, 0, (m == 0) ? 2'h2 : 2'h0, 0);
        end
        host_mode_field_i <= 3'h1;
        cfgc(0, 8'h0c, 4'h0, 0, 2'h1, 32'h000005ff);
        ce_i <= 1'b0;
        cfgc(1, 8'h0c, 4'h0, 32'h00007700, 2'h0, 0);
        ce_i <= 1'b1;
        cfgc(0, 8'h0c, 4'h0, 0, 2'h1, 32'h000005ff);
        check("line size out", 8'hff, line_size_words_o);
        host_mode_field_i <= 3'h3;
        i_pchr_host_model.look({21'h0, 8'hff, 3'h5});
        check("ub hit", 1, ub_hit_o);
        check("ub sel", 3'h5, ub_reg_sel_o);
        i_pchr_host_model.look({21'h0, 8'hfe, 3'h5});
        check("ub miss", 0, ub_hit_o);
        host_mode_field_i <= 3'h5;
        core(1'b1, 1'b0, 16'h0003);
        core(1'b0, 1'b0, 16'h0000);
        check("core latency", 16'h0003, crd);
        core(1'b0, 1'b1, 16'h0000);
        check("core base", 16'h12ff, crd);
        host_mode_field_i <= 3'h2;
        irq_req_i <= 1'b1;
        k = 0;
        for (m = 0; m < 40; m++) begin
            @(posedge clk_i);
            if (host_int_request_pin_n_o === 1'b0)
                k++;
        end
        check("pulse width", 4, k);
        irq_level_select_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        check("level pin", 0, host_int_request_pin_n_o);
        irq_req_i <= 1'b0;
        host_mode_field_i <= 3'h1;
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check("latency reset", 0, latency_count_o);
        cfgc(0, 8'h10, 4'h0, 0, 2'h1, 32'h0);
        test_done;
    end
endmodule

/* File: rtl/pchr_defines.vh */
`ifndef PCHR_DEFINES_VH
`define PCHR_DEFINES_VH

// Configuration byte offsets
`define PCHR_OFS_HDR_LAT 8'h0c
`define PCHR_OFS_MEM_BASE 8'h10

// Host mode field codes
`define PCHR_HM_SWRESET 3'h0
`define PCHR_HM_PCI 3'h1
`define PCHR_HM_UB_A 3'h2
`define PCHR_HM_UB_B 3'h3
`define PCHR_HM_SELFCFG 3'h5

// Field positions in the header/latency word
`define PCHR_CLS_LSB 0
`define PCHR_LAT_LSB 8
`define PCHR_HT_LSB 16
`define PCHR_HT_VALUE 8'h00

// Field positions in the base word
`define PCHR_PM_LSB 16
`define PCHR_GB_LSB 16
`define PCHR_MEM_CMP_LSB 12

// Reset values
`define PCHR_LAT_RST 8'h00
`define PCHR_CLS_RST 8'h00
`define PCHR_PM_RST 16'h0000

// Core-side select codes
`define PCHR_CORE_SEL_LAT 1'b0
`define PCHR_CORE_SEL_BASE 1'b1

`endif

/* File: rtl/pchr_pulse.v */
`timescale 1ns/100ps
module pchr_pulse #(
    parameter LW = 8
) (
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire start_i,
    input wire [LW-1:0] len_i,
    output reg busy_o
);
    reg [LW-1:0] cnt_q;

    // Pulse lasts len_i + 1 cycles
    always @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= {LW{1'b0}};
            busy_o <= 1'b0;
        end else if (ce_i) begin
            if (start_i && !busy_o) begin
                cnt_q <= len_i;
                busy_o <= 1'b1;
            end else if (busy_o) begin
                if (cnt_q == {LW{1'b0}}) begin
                    busy_o <= 1'b0;
                end else begin
                    cnt_q <= cnt_q - {{(LW-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule

/* File: rtl/pchr_regs.v */
`timescale 1ns/100ps
`include "pchr_defines.vh"
module pchr_regs #(
    parameter LAT_W = 8
) (
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire [2:0] host_mode_field_i,
    input wire irq_level_select_i,
    input wire pci_clk_i,
    input wire cfg_req_i,
    input wire cfg_wr_i,
    input wire [7:0] cfg_addr_i,
    input wire [3:0] cfg_be_n_i,
    input wire [31:0] cfg_wdata_i,
    input wire mem_req_i,
    input wire [31:0] pci_addr_data_lines_i,
    input wire ub_req_i,
    input wire [10:0] local_bus_addr_lines_i,
    input wire core_wr_i,
    input wire core_rd_i,
    input wire core_sel_i,
    input wire [15:0] core_wdata_i,
    input wire irq_req_i,
    output reg [31:0] cfg_rdata_o,
    output reg cfg_ack_o,
    output reg cfg_retry_o,
    output reg mem_hit_o,
    output reg [11:0] mem_reg_sel_o,
    output reg ub_hit_o,
    output reg [2:0] ub_reg_sel_o,
    output reg [15:0] core_rdata_o,
    output reg core_ack_o,
    output reg [7:0] latency_count_o,
    output reg [7:0] line_size_words_o,
    output reg host_int_request_pin_n_o
);
    // Byte-lane merge for enabled lanes (active-low enable)
    function [7:0] lane_merge;
        input [7:0] old_v;
        input [7:0] new_v;
        input en_n;
        begin
            lane_merge = en_n ? old_v : new_v;
        end
    endfunction

    // Host mode decode
    function mode_is;
        input [2:0] mode;
        input [2:0] code;
        begin
            mode_is = (mode == code);
        end
    endfunction

    reg [LAT_W-1:0] lat_q;
    reg [7:0] cls_q;
    reg [15:0] pm_q;
    reg pclk_prev_q;
    reg irq_req_prev_q;
    reg cfg_req_prev_q;
    reg mem_req_prev_q;
    reg ub_req_prev_q;
    reg [1:0] cfg_state_q;
    reg [1:0] cfg_state_d;

    // One-hot states of the configuration answer
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_HOLD = 2'b10;

    wire pclk_s;
    wire cfg_req_s;
    wire cfg_wr_s;
    wire [7:0] cfg_addr_s;
    wire [3:0] cfg_be_n_s;
    wire [31:0] cfg_wdata_s;
    wire mem_req_s;
    wire [31:0] pci_addr_s;
    wire ub_req_s;
    wire [10:0] ub_addr_s;
    wire pulse_busy;

    // Bring every link input into the core clock domain
    pchr_sync #(
        .WIDTH(1)
    ) u_sync_clk (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .d_i(pci_clk_i),
        .q_o(pclk_s)
    );

    pchr_sync #(
        .WIDTH(46)
    ) u_sync_cfg (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .d_i({cfg_req_i, cfg_wr_i, cfg_addr_i, cfg_be_n_i, cfg_wdata_i}),
        .q_o({cfg_req_s, cfg_wr_s, cfg_addr_s, cfg_be_n_s, cfg_wdata_s})
    );

    pchr_sync #(
        .WIDTH(45)
    ) u_sync_addr (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .d_i({mem_req_i, pci_addr_data_lines_i, ub_req_i,
              local_bus_addr_lines_i}),
        .q_o({mem_req_s, pci_addr_s, ub_req_s, ub_addr_s})
    );

    // Sample on falling link clock: data launched at rising edge is settled
    wire pclk_fall = pclk_prev_q && !pclk_s;

    wire mode_pci = mode_is(host_mode_field_i, `PCHR_HM_PCI);
    wire mode_swr = mode_is(host_mode_field_i, `PCHR_HM_SWRESET);
    wire mode_ub = mode_is(host_mode_field_i, `PCHR_HM_UB_A) ||
                   mode_is(host_mode_field_i, `PCHR_HM_UB_B);
    wire mode_self = mode_is(host_mode_field_i, `PCHR_HM_SELFCFG);

    wire hit_hdr = (cfg_addr_s == `PCHR_OFS_HDR_LAT);
    wire hit_base = (cfg_addr_s == `PCHR_OFS_MEM_BASE);
    // Request must stand two samples so the synced word has settled
    wire cfg_take = pclk_fall && cfg_req_s && cfg_req_prev_q &&
                    (hit_hdr || hit_base) && (cfg_state_q == ST_IDLE);
    wire cfg_mapped = mode_pci || mode_swr;
    wire cfg_go = cfg_take && mode_pci;
    wire cfg_wr_go = cfg_go && cfg_wr_s;
    wire cfg_answer = cfg_take && cfg_mapped;

    wire core_go_wr = mode_self && core_wr_i;
    wire core_go_rd = mode_self && core_rd_i;

    // Readback words with hardwired fields
    wire [31:0] hdr_word = {8'h00, `PCHR_HT_VALUE, lat_q, cls_q};
    wire [31:0] base_word = {pm_q, 16'h0000};

    // Write image: enabled lanes take new data, others keep old
    wire [31:0] cfg_old_word = hit_hdr ? hdr_word : base_word;
    wire [31:0] cfg_new_word;
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_lane
            assign cfg_new_word[8*g+7:8*g] = lane_merge(
                cfg_old_word[8*g+7:8*g], cfg_wdata_s[8*g+7:8*g],
                cfg_be_n_s[g]);
        end
    endgenerate

    // One answer per request: wait for the request to drop
    always @* begin
        cfg_state_d = cfg_state_q;
        case (cfg_state_q)
            ST_IDLE: begin
                if (cfg_answer) begin
                    cfg_state_d = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (!cfg_req_s) begin
                    cfg_state_d = ST_IDLE;
                end
            end
            default: begin
                cfg_state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            cfg_state_q <= ST_IDLE;
        end else if (ce_i) begin
            cfg_state_q <= cfg_state_d;
        end
    end

    // Latency field
    always @(posedge clk_i) begin
        if (rst_i) begin
            lat_q <= `PCHR_LAT_RST;
        end else if (ce_i) begin
            if (cfg_wr_go && hit_hdr) begin
                lat_q <= cfg_new_word[15:8];
            end else if (core_go_wr && core_sel_i == `PCHR_CORE_SEL_LAT) begin
                lat_q <= core_wdata_i[7:0];
            end
        end
    end

    // Line size field, configurator only
    always @(posedge clk_i) begin
        if (rst_i) begin
            cls_q <= `PCHR_CLS_RST;
        end else if (ce_i) begin
            if (cfg_wr_go && hit_hdr) begin
                cls_q <= cfg_new_word[7:0];
            end
        end
    end

    // Memory base high half; bits 23-16 double as Universal Bus base
    always @(posedge clk_i) begin
        if (rst_i) begin
            pm_q <= `PCHR_PM_RST;
        end else if (ce_i) begin
            if (cfg_wr_go && hit_base) begin
                pm_q <= cfg_new_word[31:16];
            end else if (core_go_wr && core_sel_i == `PCHR_CORE_SEL_BASE) begin
                pm_q <= core_wdata_i;
            end
        end
    end

    // Configuration answer: data in PCI mode, retry in software reset
    always @(posedge clk_i) begin
        if (rst_i) begin
            cfg_rdata_o <= 32'h00000000;
            cfg_ack_o <= 1'b0;
            cfg_retry_o <= 1'b0;
        end else if (ce_i) begin
            cfg_ack_o <= cfg_go;
            cfg_retry_o <= cfg_take && cfg_mapped && !mode_pci;
            if (cfg_go && !cfg_wr_s) begin
                cfg_rdata_o <= hit_hdr ? hdr_word : base_word;
            end else if (cfg_take) begin
                cfg_rdata_o <= 32'h00000000;
            end
        end
    end

    // PCI memory-space decode
    always @(posedge clk_i) begin
        if (rst_i) begin
            mem_hit_o <= 1'b0;
            mem_reg_sel_o <= 12'h000;
        end else if (ce_i) begin
            if (pclk_fall) begin
                mem_hit_o <= mode_pci && mem_req_s && mem_req_prev_q &&
                             (pci_addr_s[31:12] == {pm_q, 4'h0});
                mem_reg_sel_o <= pci_addr_s[11:0];
            end
        end
    end

    // Universal Bus decode, other base bits ignored
    always @(posedge clk_i) begin
        if (rst_i) begin
            ub_hit_o <= 1'b0;
            ub_reg_sel_o <= 3'h0;
        end else if (ce_i) begin
            if (pclk_fall) begin
                ub_hit_o <= mode_ub && ub_req_s && ub_req_prev_q &&
                            (ub_addr_s[10:3] == pm_q[7:0]);
                ub_reg_sel_o <= ub_addr_s[2:0];
            end
        end
    end

    // Core-side readback: latency or base, never line size
    always @(posedge clk_i) begin
        if (rst_i) begin
            core_rdata_o <= 16'h0000;
            core_ack_o <= 1'b0;
        end else if (ce_i) begin
            core_ack_o <= core_go_rd || core_go_wr;
            if (core_go_rd) begin
                if (core_sel_i == `PCHR_CORE_SEL_BASE) begin
                    core_rdata_o <= pm_q;
                end else begin
                    core_rdata_o <= {8'h00, lat_q};
                end
            end
        end
    end

    // Edge trackers
    always @(posedge clk_i) begin
        if (rst_i) begin
            pclk_prev_q <= 1'b0;
            irq_req_prev_q <= 1'b0;
            cfg_req_prev_q <= 1'b0;
            mem_req_prev_q <= 1'b0;
            ub_req_prev_q <= 1'b0;
        end else if (ce_i) begin
            pclk_prev_q <= pclk_s;
            irq_req_prev_q <= irq_req_i;
            cfg_req_prev_q <= cfg_req_s;
            mem_req_prev_q <= mem_req_s;
            ub_req_prev_q <= ub_req_s;
        end
    end

    // Host interrupt pulse of latency plus one cycles
    pchr_pulse #(
        .LW(LAT_W)
    ) u_pulse (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .start_i(mode_ub && !irq_level_select_i &&
                 irq_req_i && !irq_req_prev_q),
        .len_i(lat_q),
        .busy_o(pulse_busy)
    );

    // Interrupt pin, active low; level mode follows the request in Universal Bus modes
    always @(posedge clk_i) begin
        if (rst_i) begin
            host_int_request_pin_n_o <= 1'b1;
        end else if (ce_i) begin
            if (irq_level_select_i) begin
                host_int_request_pin_n_o <= !(mode_ub && irq_req_i);
            end else begin
                host_int_request_pin_n_o <= !pulse_busy;
            end
        end
    end

    // Field mirrors for the rest of the host interface
    always @(posedge clk_i) begin
        if (rst_i) begin
            latency_count_o <= `PCHR_LAT_RST;
            line_size_words_o <= `PCHR_CLS_RST;
        end else if (ce_i) begin
            latency_count_o <= lat_q;
            line_size_words_o <= cls_q;
        end
    end
endmodule

/* File: rtl/pchr_sync.v */
`timescale 1ns/100ps
module pchr_sync #(
    parameter WIDTH = 1
) (
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire [WIDTH-1:0] d_i,
    output reg [WIDTH-1:0] q_o
);
    reg [WIDTH-1:0] meta_q;

    // Two-stage synchroniser, first stage read only by the second
    always @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= {WIDTH{1'b0}};
            q_o <= {WIDTH{1'b0}};
        end else if (ce_i) begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule
